// ---- cop_params.svh ----
// Constants for the converter option control block
`ifndef COP_PARAMS_SVH
`define COP_PARAMS_SVH
`define COP_CMD_OPTIONS 8'hE5
`define COP_RESET_VAL 16'h1184
`define COP_WR_MASK 16'h7FFF
`define COP_NVM_MASK 16'h7FE7
`define COP_MH_RESTORE0 16'h0009
`define COP_MH_RESTORE1 16'h000F
`define COP_ML_RESTORE0 16'hFFF7
`define COP_ML_RESTORE1 16'hFFF1
`define COP_AVG_CODE16 2'h0
`define COP_AVG_CODE1 2'h1
`define COP_AVG_CODE8 2'h2
`define COP_AVG_CODE32 2'h3
`define COP_SHIFT16 3'h4
`define COP_SHIFT1 3'h0
`define COP_SHIFT8 3'h3
`define COP_SHIFT32 3'h5
`define COP_FAULT_W 8
`endif

// ---- cop_pkg.sv ----
// Types and helpers for the converter option control block
`include "cop_params.svh"
package cop_pkg;
   typedef struct packed {
      logic rsv15;
      logic margin_high_restore_select;
      logic margin_low_restore_select;
      logic rsv12;
      logic vout_reset_on_shutdown;
      logic rsv10;
      logic [1:0] voltage_readback_divider;
      logic auto_alert_mask_enable;
      logic [1:0] averaging_select;
      logic limit_check_override;
      logic voltage_only_measure;
      logic monitor_converter_enable;
      logic reset_output_select;
      logic neg_current_limit_disable;
   } cop_opt_type;

   typedef logic [15:0] cop_word_type;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } cop_sample_type;

   // Number of samples per averaged result, as a power of two
   function automatic logic [2:0] cop_avg_shift(input logic [1:0] sel);
      case (sel)
         `COP_AVG_CODE16: cop_avg_shift = `COP_SHIFT16;
         `COP_AVG_CODE1: cop_avg_shift = `COP_SHIFT1;
         `COP_AVG_CODE8: cop_avg_shift = `COP_SHIFT8;
         default: cop_avg_shift = `COP_SHIFT32;
      endcase
   endfunction
endpackage

// ---- cop_averager.sv ----
// Accumulating averager for one telemetry reading
`timescale 1ns/10ps
`include "cop_params.svh"
module cop_averager
   import cop_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input cop_pkg::cop_sample_type smp,
   input wire logic run,
   input wire logic [1:0] avg_sel,
   output logic [15:0] reading
);
   import cop_pkg::*;
   logic [20:0] acc_r, acc_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [15:0] reading_r, reading_nxt;
   logic [2:0] shift;
   logic [20:0] sum;

   always_comb begin
      acc_nxt = acc_r;
      cnt_nxt = cnt_r;
      reading_nxt = reading_r;
      shift = cop_avg_shift(avg_sel);
      sum = acc_r + {5'h00, smp.data};
      // Held while stopped; a partial sum across a mode change is accepted
      if (run && smp.valid) begin
         if (shift == `COP_SHIFT1) begin
            reading_nxt = smp.data;
            acc_nxt = 21'h000000;
            cnt_nxt = 6'h00;
         end else if ((cnt_r + 6'h01) >= (6'h01 << shift)) begin
            reading_nxt = 16'(sum >> shift);
            acc_nxt = 21'h000000;
            cnt_nxt = 6'h00;
         end else begin
            acc_nxt = sum;
            cnt_nxt = cnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_r <= 21'h000000;
         cnt_r <= 6'h00;
         reading_r <= 16'h0000;
      end else begin
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
         reading_r <= reading_nxt;
      end
   end

   assign reading = reading_r;
endmodule

// ---- cop_option_ctrl.sv ----
// Options word of the converter and the logic that it steers
`timescale 1ns/10ps
`include "cop_params.svh"
module cop_option_ctrl
   import cop_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] CMD_CODE,
   input wire logic WR_REQ,
   input cop_pkg::cop_word_type WR_DATA,
   input wire logic RD_REQ,
   output cop_pkg::cop_word_type RD_DATA,
   output logic RD_ACK,
   input wire logic STORE_ALL,
   output logic NVM_WR_STROBE,
   output cop_pkg::cop_word_type NVM_WR_DATA,
   input wire logic NVM_RESTORE,
   input cop_pkg::cop_word_type NVM_DATA,
   output logic NEG_CURRENT_LIMIT_DISABLE,
   input wire logic POWER_GOOD_IN,
   input wire logic RESET_ACTIVE_IN,
   output logic RESET_OR_GOOD_PIN,
   output logic MONITOR_CONVERTER_ENABLE,
   output logic VOLTAGE_ONLY_MEASURE,
   input cop_pkg::cop_sample_type VOUT_SAMPLE,
   input cop_pkg::cop_sample_type IOUT_SAMPLE,
   input cop_pkg::cop_sample_type TEMP_SAMPLE,
   output logic [15:0] OUTPUT_VOLTAGE_READING,
   output logic [15:0] OUTPUT_CURRENT_READING,
   output logic [15:0] TEMPERATURE_READING,
   output logic LIMIT_CHECK_OVERRIDE,
   input wire logic WRITE_DATA_INVALID,
   output logic INVALID_DATA_FLAG_SET,
   input wire logic ALERT_RESPONSE_DONE,
   input wire logic [`COP_FAULT_W-1:0] FAULT_SOURCES,
   output logic [`COP_FAULT_W-1:0] ALERT_MASK_SET,
   output logic [15:0] MARGIN_HIGH_RESTORE,
   output logic [15:0] MARGIN_LOW_RESTORE,
   input wire logic SHUTDOWN_EVENT,
   output logic VOUT_RESTORE_DEFAULT
);
   import cop_pkg::*;

   cop_opt_type opt_r, opt_nxt;
   cop_word_type rd_data_r, rd_data_nxt;
   logic rd_ack_r, rd_ack_nxt;
   logic nvm_wr_r, nvm_wr_nxt;
   cop_word_type nvm_data_r, nvm_data_nxt;
   logic inval_r, inval_nxt;
   logic [`COP_FAULT_W-1:0] amask_r, amask_nxt;
   logic [15:0] mh_r, mh_nxt, ml_r, ml_nxt;
   logic vrst_r, vrst_nxt;
   logic pin_r, pin_nxt;
   logic [1:0] pg_sync_r, ra_sync_r;
   logic hit;

   always_comb begin
      hit = (CMD_CODE == `COP_CMD_OPTIONS);
      opt_nxt = opt_r;
      rd_data_nxt = rd_data_r;
      rd_ack_nxt = 1'b0;
      nvm_wr_nxt = 1'b0;
      nvm_data_nxt = nvm_data_r;
      // Word write from the command decoder, bytes already joined
      if (WR_REQ && hit) begin
         opt_nxt = cop_opt_type'((cop_word_type'(opt_r) & ~`COP_WR_MASK)
                   | (WR_DATA & `COP_WR_MASK));
      end else if (NVM_RESTORE) begin
         opt_nxt = cop_opt_type'((cop_word_type'(opt_r) & ~`COP_NVM_MASK)
                   | (NVM_DATA & `COP_NVM_MASK));
      end
      if (RD_REQ && hit) begin
         rd_data_nxt = cop_word_type'(opt_r);
         rd_ack_nxt = 1'b1;
      end
      if (STORE_ALL) begin
         nvm_wr_nxt = 1'b1;
         nvm_data_nxt = cop_word_type'(opt_r) & `COP_NVM_MASK;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         opt_r <= cop_opt_type'(`COP_RESET_VAL);
         rd_data_r <= 16'h0000;
         rd_ack_r <= 1'b0;
         nvm_wr_r <= 1'b0;
         nvm_data_r <= 16'h0000;
      end else begin
         opt_r <= opt_nxt;
         rd_data_r <= rd_data_nxt;
         rd_ack_r <= rd_ack_nxt;
         nvm_wr_r <= nvm_wr_nxt;
         nvm_data_r <= nvm_data_nxt;
      end
   end

   // Pin-level status inputs come from the analog side
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pg_sync_r <= 2'h0;
         ra_sync_r <= 2'h0;
      end else begin
         pg_sync_r <= {pg_sync_r[0], POWER_GOOD_IN};
         ra_sync_r <= {ra_sync_r[0], RESET_ACTIVE_IN};
      end
   end

   always_comb begin
      // Reset function drives low while reset is active
      pin_nxt = opt_r.reset_output_select ? ~ra_sync_r[1]
                : pg_sync_r[1];
      // Override only suppresses new reports; nothing fires on its release
      inval_nxt = WRITE_DATA_INVALID
                  & ~opt_r.limit_check_override;
      // Without auto mask nothing is masked here; host masks sources
      amask_nxt = (ALERT_RESPONSE_DONE && opt_r.auto_alert_mask_enable)
                  ? FAULT_SOURCES : '0;
      mh_nxt = opt_r.margin_high_restore_select ? `COP_MH_RESTORE1
               : `COP_MH_RESTORE0;
      ml_nxt = opt_r.margin_low_restore_select ? `COP_ML_RESTORE1
               : `COP_ML_RESTORE0;
      vrst_nxt = SHUTDOWN_EVENT & opt_r.vout_reset_on_shutdown;
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_r <= 1'b0;
         inval_r <= 1'b0;
         amask_r <= '0;
         mh_r <= `COP_MH_RESTORE0;
         ml_r <= `COP_ML_RESTORE0;
         vrst_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
         inval_r <= inval_nxt;
         amask_r <= amask_nxt;
         mh_r <= mh_nxt;
         ml_r <= ml_nxt;
         vrst_r <= vrst_nxt;
      end
   end

   logic run_v, run_it;
   assign run_v = opt_r.monitor_converter_enable;
   assign run_it = opt_r.monitor_converter_enable
                   & ~opt_r.voltage_only_measure;

   // One depth for all three readings; mode change may cut a sum short
   cop_averager u_avg_vout (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .smp(VOUT_SAMPLE),
      .run(run_v),
      .avg_sel(opt_r.averaging_select),
      .reading(OUTPUT_VOLTAGE_READING)
   );
   cop_averager u_avg_iout (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .smp(IOUT_SAMPLE),
      .run(run_it),
      .avg_sel(opt_r.averaging_select),
      .reading(OUTPUT_CURRENT_READING)
   );
   cop_averager u_avg_temp (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .smp(TEMP_SAMPLE),
      .run(run_it),
      .avg_sel(opt_r.averaging_select),
      .reading(TEMPERATURE_READING)
   );

   assign RD_DATA = rd_data_r;
   assign RD_ACK = rd_ack_r;
   assign NVM_WR_STROBE = nvm_wr_r;
   assign NVM_WR_DATA = nvm_data_r;
   assign NEG_CURRENT_LIMIT_DISABLE = opt_r.neg_current_limit_disable;
   assign RESET_OR_GOOD_PIN = pin_r;
   assign MONITOR_CONVERTER_ENABLE = opt_r.monitor_converter_enable;
   assign VOLTAGE_ONLY_MEASURE = opt_r.voltage_only_measure;
   assign LIMIT_CHECK_OVERRIDE = opt_r.limit_check_override;
   assign INVALID_DATA_FLAG_SET = inval_r;
   assign ALERT_MASK_SET = amask_r;
   assign MARGIN_HIGH_RESTORE = mh_r;
   assign MARGIN_LOW_RESTORE = ml_r;
   assign VOUT_RESTORE_DEFAULT = vrst_r;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   a_write_lands: assert property (
      (WR_REQ && hit) |=> (cop_word_type'(opt_r)
      == ($past(WR_DATA) & `COP_WR_MASK))) else $error("write lost");
   a_read_answer: assert property (
      (RD_REQ && hit) |=> (RD_ACK
      && RD_DATA == $past(cop_word_type'(opt_r)))) else $error("bad read");
   a_read_unmapped: assert property (
      !(RD_REQ && hit) |=> !RD_ACK) else $error("stray ack");
   a_nvm_excludes: assert property (
      NVM_WR_STROBE |-> (NVM_WR_DATA[4:3] == 2'h0))
      else $error("volatile bits stored");
   a_restore_keeps: assert property (
      (NVM_RESTORE && !(WR_REQ && hit)) |=>
      ((opt_r.voltage_only_measure == $past(opt_r.voltage_only_measure))
      && (opt_r.limit_check_override
      == $past(opt_r.limit_check_override))))
      else $error("volatile bit restored");
   a_override_quiet: assert property (
      (WRITE_DATA_INVALID && opt_r.limit_check_override)
      |=> !INVALID_DATA_FLAG_SET) else $error("flag under override");
   a_invalid_report: assert property (
      (WRITE_DATA_INVALID && !opt_r.limit_check_override)
      |=> INVALID_DATA_FLAG_SET) else $error("invalid write missed");
   a_automask_on: assert property (
      (ALERT_RESPONSE_DONE && opt_r.auto_alert_mask_enable)
      |=> (ALERT_MASK_SET == $past(FAULT_SOURCES)))
      else $error("mask missed");
   a_automask_off: assert property (
      !opt_r.auto_alert_mask_enable |=> (ALERT_MASK_SET == '0))
      else $error("mask without enable");
   a_margin_hi: assert property (
      ##1 (MARGIN_HIGH_RESTORE == ($past(opt_r.margin_high_restore_select)
      ? `COP_MH_RESTORE1 : `COP_MH_RESTORE0)))
      else $error("bad margin high");
   a_margin_lo: assert property (
      ##1 (MARGIN_LOW_RESTORE == ($past(opt_r.margin_low_restore_select)
      ? `COP_ML_RESTORE1 : `COP_ML_RESTORE0)))
      else $error("bad margin low");
   a_hold_readings: assert property (
      (!opt_r.monitor_converter_enable && !(WR_REQ && hit)
      && !NVM_RESTORE)[*2] |-> $stable(OUTPUT_VOLTAGE_READING))
      else $error("reading moved");
   a_volt_only_freeze: assert property (
      (opt_r.voltage_only_measure && !(WR_REQ && hit)
      && !NVM_RESTORE)[*2] |-> $stable(OUTPUT_CURRENT_READING))
      else $error("current moved");
   a_vout_reset: assert property (
      (SHUTDOWN_EVENT && opt_r.vout_reset_on_shutdown)
      |=> VOUT_RESTORE_DEFAULT) else $error("no vout reset");

   c_write: cover property (WR_REQ && hit ##1 RD_REQ && hit ##1 RD_ACK);
   c_store: cover property (STORE_ALL ##1 NVM_WR_STROBE);
   c_automask: cover property (ALERT_RESPONSE_DONE
      && opt_r.auto_alert_mask_enable && FAULT_SOURCES != '0);
   c_override: cover property (WRITE_DATA_INVALID
      && opt_r.limit_check_override);
endmodule

// ---- cop_host_model.sv ----
// Host controller model issuing word accesses to the options block
`timescale 1ns/10ps
module cop_host_model
   import cop_pkg::*;
(
   input wire logic clk,
   output logic [7:0] cmd_code,
   output logic wr_req,
   output cop_pkg::cop_word_type wr_data,
   output logic rd_req,
   input cop_pkg::cop_word_type rd_data,
   input wire logic rd_ack,
   output logic store_all
);
   initial begin
      cmd_code = 8'h00;
      wr_req = 1'b0;
      wr_data = 16'h0000;
      rd_req = 1'b0;
      store_all = 1'b0;
   end
   // Released lines show the inverse so stale values never pass
   task automatic write_word(input logic [7:0] code, input logic [7:0] lo,
         input logic [7:0] hi);
      @(negedge clk);
      cmd_code = code;
      wr_data = {hi, lo};
      wr_req = 1'b1;
      @(negedge clk);
      wr_req = 1'b0;
      wr_data = ~wr_data;
      cmd_code = ~code;
   endtask
   task automatic read_word(input logic [7:0] code, output cop_word_type d,
         output logic ack);
      @(negedge clk);
      cmd_code = code;
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      cmd_code = ~code;
      ack = rd_ack;
      d = rd_data;
   endtask
   task automatic store_defaults();
      @(negedge clk);
      store_all = 1'b1;
      @(negedge clk);
      store_all = 1'b0;
   endtask
endmodule

// ---- converter_option_control_bench.sv ----
// Self-checking bench for the options word block
`timescale 1ns/10ps
module converter_option_control_bench;
   import cop_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] cmd_code;
   logic wr_req, rd_req, rd_ack, store_all, nvm_strobe, neg_dis, pin;
   logic mon_en, vonly, lco, inval_flag, vrst;
   cop_word_type wr_data, rd_data, nvm_wdata;
   cop_word_type nvm_data = 16'h0000;
   logic nvm_restore = 1'b0, pg_in = 1'b0, ra_in = 1'b0, inval = 1'b0;
   logic resp_done = 1'b0, shut = 1'b0;
   logic [7:0] faults = 8'h00;
   logic [7:0] amask;
   cop_sample_type s_v = '0, s_i = '0, s_t = '0;
   logic [15:0] r_v, r_i, r_t, mh, ml;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   int opt = 32'h1184, ev = 0, ei = 0, et = 0;
   int ntab[4] = '{16, 1, 8, 32};

   always #20 ref_clk = ~ref_clk;

   cop_host_model cop_host_model_inst (.clk(ref_clk), .cmd_code(cmd_code),
      .wr_req(wr_req), .wr_data(wr_data), .rd_req(rd_req),
      .rd_data(rd_data), .rd_ack(rd_ack), .store_all(store_all));

   cop_option_ctrl cop_option_ctrl_inst (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CMD_CODE(cmd_code),
      .WR_REQ(wr_req), .WR_DATA(wr_data), .RD_REQ(rd_req),
      .RD_DATA(rd_data), .RD_ACK(rd_ack), .STORE_ALL(store_all),
      .NVM_WR_STROBE(nvm_strobe), .NVM_WR_DATA(nvm_wdata),
      .NVM_RESTORE(nvm_restore), .NVM_DATA(nvm_data),
      .NEG_CURRENT_LIMIT_DISABLE(neg_dis), .POWER_GOOD_IN(pg_in),
      .RESET_ACTIVE_IN(ra_in), .RESET_OR_GOOD_PIN(pin),
      .MONITOR_CONVERTER_ENABLE(mon_en), .VOLTAGE_ONLY_MEASURE(vonly),
      .VOUT_SAMPLE(s_v), .IOUT_SAMPLE(s_i), .TEMP_SAMPLE(s_t),
      .OUTPUT_VOLTAGE_READING(r_v), .OUTPUT_CURRENT_READING(r_i),
      .TEMPERATURE_READING(r_t), .LIMIT_CHECK_OVERRIDE(lco),
      .WRITE_DATA_INVALID(inval), .INVALID_DATA_FLAG_SET(inval_flag),
      .ALERT_RESPONSE_DONE(resp_done), .FAULT_SOURCES(faults),
      .ALERT_MASK_SET(amask), .MARGIN_HIGH_RESTORE(mh),
      .MARGIN_LOW_RESTORE(ml), .SHUTDOWN_EVENT(shut),
      .VOUT_RESTORE_DEFAULT(vrst));

   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic outs();
      check(neg_dis, opt[0]);
      check(mon_en, opt[2]);
      check(vonly, opt[3]);
      check(lco, opt[4]);
      check(mh, opt[14] ? 16'h000F : 16'h0009);
      check(ml, opt[13] ? 16'hFFF1 : 16'hFFF7);
   endtask

   task automatic rdchk(input logic [7:0] code, input logic ack_e);
      cop_word_type d;
      logic a;
      cop_host_model_inst.read_word(code, d, a);
      check(a, ack_e);
      if (ack_e)
         check(d, opt[15:0]);
   endtask

   task automatic wr(input int v);
      cop_host_model_inst.write_word(8'hE5, v[7:0], v[15:8]);
      opt = v & 16'h7FFF;
   endtask

   task automatic events_chk();
      logic [7:0] f;
      f = 8'($urandom);
      @(negedge ref_clk);
      inval = 1'b1;
      resp_done = 1'b1;
      shut = 1'b1;
      faults = f;
      @(negedge ref_clk);
      inval = 1'b0;
      resp_done = 1'b0;
      shut = 1'b0;
      check(inval_flag, !opt[4]);
      check(amask, opt[7] ? f : 8'h00);
      check(vrst, opt[11]);
   endtask

   // Samples on all three channels; the model divides by the number of samples fed, n
   task automatic feed(input int n);
      int sv = 0, si = 0, st = 0;
      repeat (n) begin
         @(negedge ref_clk);
         s_v = {1'b1, 16'($urandom)};
         s_i = {1'b1, 16'($urandom)};
         s_t = {1'b1, 16'($urandom)};
         sv += s_v.data;
         si += s_i.data;
         st += s_t.data;
      end
      @(negedge ref_clk);
      s_v.valid = 1'b0;
      s_i.valid = 1'b0;
      s_t.valid = 1'b0;
      @(negedge ref_clk);
      if (opt[2])
         ev = sv / n;
      if (opt[2] && !opt[3]) begin
         ei = si / n;
         et = st / n;
      end
      check(r_v, ev);
      check(r_i, ei);
      check(r_t, et);
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'hFE06));
      repeat (8) @(negedge ref_clk);
      sys_rst = 1'b0;
      rdchk(8'hE5, 1'b1);
      outs();
      for (int i = 0; i < 6; i++) begin
         wr(i == 0 ? 32'hFFFF : $urandom);
         rdchk(8'hE5, 1'b1);
         outs();
      end
      cop_host_model_inst.write_word(8'hE4, 8'hFF, 8'hFF);
      rdchk(8'hE4, 1'b0);
      rdchk(8'hE5, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr((i >> 1) & 2);
         pg_in = i[0];
         ra_in = i[1];
         repeat (4) @(negedge ref_clk);
         check(pin, opt[1] ? !ra_in : pg_in);
      end
      wr(16'h0894);
      events_chk();
      wr(16'h0004);
      repeat (3) begin
         @(negedge ref_clk);
         check(inval_flag, 1'b0);
      end
      events_chk();
      wr(16'h7FFF);
      cop_host_model_inst.store_defaults();
      check(nvm_strobe, 1'b1);
      check(nvm_wdata, opt & 16'h7FE7);
      nvm_data = 16'($urandom);
      nvm_restore = 1'b1;
      @(negedge ref_clk);
      nvm_restore = 1'b0;
      opt = (opt & 16'h0018) | (nvm_data & 16'h7FE7);
      rdchk(8'hE5, 1'b1);
      outs();
      for (int k = 0; k < 4; k++) begin
         wr(((k + 1) % 4) << 5 | 4);
         feed(ntab[(k + 1) % 4]);
      end
      wr(16'h0020);
      feed(3);
      wr(16'h002C);
      feed(1);
      // Second reset in mid-run brings back the reset word and readings
      @(negedge ref_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      opt = 32'h1184;
      ev = 0;
      ei = 0;
      et = 0;
      rdchk(8'hE5, 1'b1);
      outs();
      check(r_v, ev);
      check(r_i, ei);
      check(r_t, et);
      final_report();
   end
endmodule
